/* core/context_reg.sv */
// Page-table context pointer with hardware-written page-pair field
`timescale 1ns/1ns
module context_reg
    import tlb_regs_pkg::*;
(
    input wire logic clock,
    input wire logic rst_n,
    input wire logic sw_wr,
    input wire logic [63:0] sw_data,
    input wire logic tlb_exc,
    input wire logic [63:0] fault_vaddr,
    output context_s ctx
);

    // ========================================
    // State
    typedef struct packed {
        context_s c;
    } st_s;
    st_s st_reg;
    st_s st_next;

    // Software writes the base; exceptions load the page pair
    always_comb begin
        st_next = st_reg;
        if (sw_wr) begin
            st_next.c.ptb = sw_data[63:63-PTB_W+1];
        end
        if (tlb_exc) begin
            st_next.c.vpp = fault_vaddr[VPP_MSB:VPP_LSB];
        end else if (sw_wr) begin
            st_next.c.vpp = sw_data[CTX_VPP_LSB+VPP_W-1:CTX_VPP_LSB];
        end
        st_next.c.zero = 4'h0;
    end

    always_ff @(posedge clock) begin
        if (!rst_n) begin
            st_reg <= '0;
        end else begin
            st_reg <= st_next;
        end
    end

    assign ctx = st_reg.c;

endmodule : context_reg

/* core/replace_counter.sv */
// Decrementing replacement index with wired lower bound
`timescale 1ns/1ns
module replace_counter
    import tlb_regs_pkg::*;
(
    input wire logic clock,
    input wire logic rst_n,
    input wire logic retire,
    input wire logic reload,
    input wire logic [IDX_W-1:0] lower,
    output logic [IDX_W-1:0] index
);

    // ========================================
    // State
    typedef struct packed {
        logic [IDX_W-1:0] cnt;
    } st_s;
    st_s st_reg;
    st_s st_next;

    // Next count: reload wins over a retire in the same cycle
    always_comb begin
        st_next = st_reg;
        if (reload) begin
            st_next.cnt = IDX_TOP;
        end else if (retire) begin
            if (st_reg.cnt <= lower || st_reg.cnt == '0) begin
                st_next.cnt = IDX_TOP;
            end else begin
                st_next.cnt = st_reg.cnt - 6'h01;
            end
        end
    end

    always_ff @(posedge clock) begin
        if (!rst_n) begin
            st_reg <= '{cnt: IDX_TOP};
        end else begin
            st_reg <= st_next;
        end
    end

    // bound held by wrap test above
    assign index = st_reg.cnt;

endmodule : replace_counter

/* core/tlb_mgmt_system_regs.sv */
// TLB management system-coprocessor registers: top module
`timescale 1ns/1ns

module tlb_mgmt_system_regs
    import tlb_regs_pkg::*;
(
    input wire logic clock,
    input wire logic rst_n,
    input reg_move_s mv,
    input wire logic retire,
    input wire logic probe_done,
    input wire logic probe_hit,
    input wire logic [IDX_W-1:0] probe_idx,
    input wire logic tlb_read,
    input wire logic tlb_write_idx,
    input wire logic tlb_write_rand,
    input tlb_lo_pair_s rd_pair,
    input wire logic [IDX_W-1:0] fixed_count,
    input wire logic tlb_exc,
    input wire logic [63:0] fault_vaddr,
    input wire logic hit_valid,
    input wire logic hit_dirty,
    input wire logic hit_global,
    input wire logic access_hit,
    input wire logic access_store,
    output logic [63:0] rd_data,
    output tlb_write_s tlb_wr,
    output logic address_space_id_ignore,
    output logic load_miss_exc,
    output logic store_miss_exc,
    output logic store_prot
);

    // ========================================
    // State
    typedef struct packed {
        logic probe_fail;
        logic [IDX_W-1:0] idx;
        lo_entry_s even_lo;
        lo_entry_s odd_lo;
        logic [63:0] rd;
        tlb_write_s wr;
        logic address_space_id_ign;
        logic lmiss;
        logic smiss;
        logic sprot;
    } st_s;
    st_s st_reg;
    st_s st_next;

    logic [IDX_W-1:0] rand_idx;
    context_s ctx;
    logic wired_wr;
    logic ctx_wr;

    // Write strobes for sub-blocks
    assign wired_wr = mv.wr && mv.num == REG_FIXED_COUNT;
    assign ctx_wr = mv.wr && mv.num == REG_CONTEXT;

    // ========================================
    // Replacement counter
    replace_counter u_rc (
        .clock(clock),
        .rst_n(rst_n),
        .retire(retire),
        .reload(wired_wr),
        .lower(fixed_count),
        .index(rand_idx)
    );

    // ========================================
    // Context pointer
    context_reg u_ctx (
        .clock(clock),
        .rst_n(rst_n),
        .sw_wr(ctx_wr),
        .sw_data(mv.data),
        .tlb_exc(tlb_exc),
        .fault_vaddr(fault_vaddr),
        .ctx(ctx)
    );

    // Register updates, TLB transfers and lookup qualifiers
    always_comb begin
        st_next = st_reg;
        st_next.wr.wr = 1'b0;
        // Software moves into the index and low-entry registers
        if (mv.wr) begin
            unique case (mv.num)
                REG_PROBE_INDEX: begin
                    st_next.idx = mv.data[IDX_W-1:0];
                    st_next.probe_fail = mv.data[PROBE_FAIL_BIT];
                end
                REG_EVEN_LO: begin
                    st_next.even_lo = clean_lo(mv.data);
                end
                REG_ODD_LO: begin
                    st_next.odd_lo = clean_lo(mv.data);
                end
                default: begin
                end
            endcase
        end
        // Probe result overrides a same-cycle software write of the fail flag, and of the index only on a hit
        if (probe_done) begin
            st_next.probe_fail = !probe_hit;
            if (probe_hit) begin
                st_next.idx = probe_idx;
            end
        end
        // TLB read loads both halves; global copied to both
        if (tlb_read) begin
            st_next.even_lo = make_lo(rd_pair.pfn0, rd_pair.attr0,
                rd_pair.dirty0, rd_pair.valid0, rd_pair.global_bit);
            st_next.odd_lo = make_lo(rd_pair.pfn1, rd_pair.attr1,
                rd_pair.dirty1, rd_pair.valid1, rd_pair.global_bit);
        end
        // TLB write drives the entry array
        if (tlb_write_idx || tlb_write_rand) begin
            st_next.wr.wr = 1'b1;
            st_next.wr.idx = tlb_write_rand ? rand_idx : st_reg.idx;
            st_next.wr.pair.pfn0 = st_reg.even_lo.phys_frame_number;
            st_next.wr.pair.attr0 = st_reg.even_lo.attr;
            st_next.wr.pair.dirty0 = st_reg.even_lo.dirty;
            st_next.wr.pair.valid0 = st_reg.even_lo.valid;
            st_next.wr.pair.pfn1 = st_reg.odd_lo.phys_frame_number;
            st_next.wr.pair.attr1 = st_reg.odd_lo.attr;
            st_next.wr.pair.dirty1 = st_reg.odd_lo.dirty;
            st_next.wr.pair.valid1 = st_reg.odd_lo.valid;
            st_next.wr.pair.global_bit = st_reg.even_lo.global_bit &&
                st_reg.odd_lo.global_bit;
        end
        st_next.address_space_id_ign = hit_global;
        st_next.lmiss = access_hit && !hit_valid && !access_store;
        st_next.smiss = access_hit && !hit_valid && access_store;
        st_next.sprot = access_hit && hit_valid && access_store &&
            !hit_dirty;
        // Read mux, one cycle after the request number
        unique case (mv.num)
            REG_PROBE_INDEX: begin
                st_next.rd = {32'h0, st_reg.probe_fail, 25'h0, st_reg.idx};
            end
            REG_REPLACE: begin
                st_next.rd = {58'h0, rand_idx};
            end
            REG_EVEN_LO: begin
                st_next.rd = st_reg.even_lo;
            end
            REG_ODD_LO: begin
                st_next.rd = st_reg.odd_lo;
            end
            REG_CONTEXT: begin
                st_next.rd = ctx;
            end
            default: begin
                st_next.rd = 64'h0;
            end
        endcase
    end

    // Register all state
    always_ff @(posedge clock) begin
        if (!rst_n) begin
            st_reg <= '0;
        end else begin
            st_reg <= st_next;
        end
    end

    // Outputs straight from flip-flops
    assign rd_data = st_reg.rd;
    assign tlb_wr = st_reg.wr;
    assign address_space_id_ignore = st_reg.address_space_id_ign;
    assign load_miss_exc = st_reg.lmiss;
    assign store_miss_exc = st_reg.smiss;
    assign store_prot = st_reg.sprot;

endmodule : tlb_mgmt_system_regs

/* core/tlb_regs_pkg.sv */
// Shared constants, types and field layouts for the TLB management registers
package tlb_regs_pkg;

    // ========================================
    // Register numbers
    localparam logic [4:0] REG_PROBE_INDEX = 5'h00;
    localparam logic [4:0] REG_REPLACE = 5'h01;
    localparam logic [4:0] REG_EVEN_LO = 5'h02;
    localparam logic [4:0] REG_ODD_LO = 5'h03;
    localparam logic [4:0] REG_CONTEXT = 5'h04;
    localparam logic [4:0] REG_FIXED_COUNT = 5'h06;

    // ========================================
    // Sizes and field positions
    localparam int TLB_ENTRIES = 64;
    localparam int IDX_W = 6;
    localparam logic [5:0] IDX_TOP = 6'h3f;
    localparam int PROBE_FAIL_BIT = 31;
    localparam int PFN_W = 36;
    localparam int PTB_W = 41;
    localparam int VPP_W = 19;
    localparam int VPP_LSB = 13;
    localparam int VPP_MSB = 31;
    localparam int CTX_VPP_LSB = 4;

    // ========================================
    // Low-entry layout: 22 zero, PHYS_FRAME_NUMBER 36, attr 3, dirty, valid, global
    // Full 64 bits wide so a register move casts onto it bit for bit
    typedef struct packed {
        logic [21:0] zero;
        logic [PFN_W-1:0] phys_frame_number;
        logic [2:0] attr;
        logic dirty;
        logic valid;
        logic global_bit;
    } lo_entry_s;

    // Stored TLB entry low half pair, one global bit
    typedef struct packed {
        logic [PFN_W-1:0] pfn0;
        logic [2:0] attr0;
        logic dirty0;
        logic valid0;
        logic [PFN_W-1:0] pfn1;
        logic [2:0] attr1;
        logic dirty1;
        logic valid1;
        logic global_bit;
    } tlb_lo_pair_s;

    // Register move request from the pipeline
    typedef struct packed {
        logic wr;
        logic [4:0] num;
        logic [63:0] data;
    } reg_move_s;

    // Bundle the TLB array receives on a write
    typedef struct packed {
        logic wr;
        logic [IDX_W-1:0] idx;
        tlb_lo_pair_s pair;
    } tlb_write_s;

    // Context register fields
    typedef struct packed {
        logic [PTB_W-1:0] ptb;
        logic [VPP_W-1:0] vpp;
        logic [3:0] zero;
    } context_s;

    // Expand a stored half into register format
    function automatic lo_entry_s make_lo(logic [PFN_W-1:0] p,
            logic [2:0] a, logic d, logic v, logic g);
        lo_entry_s r;
        r.zero = 22'h0;
        r.phys_frame_number = p;
        r.attr = a;
        r.dirty = d;
        r.valid = v;
        r.global_bit = g;
        return r;
    endfunction : make_lo

    // Clear reserved bits of a written low-entry value
    function automatic lo_entry_s clean_lo(logic [63:0] w);
        lo_entry_s r;
        r = lo_entry_s'(w);
        r.zero = 22'h0;
        return r;
    endfunction : clean_lo

endpackage : tlb_regs_pkg

/* verif/tlb_entry_model.sv */
// Behavioural TLB entry array at the far side of the register block
`timescale 1ns/1ns
module tlb_entry_model
    import tlb_regs_pkg::*;
(
    input wire logic clock,
    input tlb_write_s wr,
    input wire logic [IDX_W-1:0] rd_idx,
    output tlb_lo_pair_s rd_pair
);
    // One stored pair per entry; unwritten entries stay unknown
    tlb_lo_pair_s mem [TLB_ENTRIES];
    always @(posedge clock) begin
        if (wr.wr) begin
            mem[wr.idx] <= wr.pair;
        end
    end
    always_comb begin
        rd_pair = mem[rd_idx];
    end
endmodule : tlb_entry_model

/* verif/tlb_mgmt_system_regs_checker.sv */
// Assertion checker for the TLB management registers
`timescale 1ns/1ns
module tlb_mgmt_system_regs_checker
    import tlb_regs_pkg::*;
(
    input wire logic clock,
    input wire logic rst_n,
    input reg_move_s mv,
    input wire logic probe_done,
    input wire logic probe_hit,
    input wire logic tlb_write_rand,
    input wire logic tlb_exc,
    input wire logic [63:0] fault_vaddr,
    input wire logic hit_valid,
    input wire logic hit_dirty,
    input wire logic hit_global,
    input wire logic access_hit,
    input wire logic access_store,
    input wire logic [63:0] rd_data,
    input tlb_write_s tlb_wr,
    input wire logic address_space_id_ignore,
    input wire logic load_miss_exc,
    input wire logic store_miss_exc,
    input wire logic store_prot
);
    // ========================================
    // Clocking and helpers
    default clocking @(posedge clock); endclocking
    default disable iff (!rst_n);
    // Page-pair slice, so that $past sees a plain signal
    logic [18:0] vpn;
    assign vpn = fault_vaddr[VPP_MSB:VPP_LSB];
    // Probe, a quiet cycle, then a read of the index register
    sequence probe_rd;
        probe_done ##1 (!probe_done && !mv.wr)
            ##1 (mv.num == REG_PROBE_INDEX && !mv.wr && !probe_done);
    endsequence
    // Fault, a quiet cycle, then a read of the context register
    sequence fault_rd;
        tlb_exc ##1 (!tlb_exc && !mv.wr)
            ##1 (mv.num == REG_CONTEXT && !mv.wr && !tlb_exc);
    endsequence
    // ========================================
    // Properties
    idx_zero_a: assert property (
        mv.num == REG_PROBE_INDEX |=> rd_data[63:32] == '0
        && rd_data[30:IDX_W] == '0) else $error("index reserved set");
    probe_flag_a: assert property (
        probe_rd |=> rd_data[PROBE_FAIL_BIT] == !$past(probe_hit, 3))
        else $error("probe fail flag wrong");
    unmapped_zero_a: assert property (
        mv.num == 5'h1f |=> rd_data == '0) else $error("unmapped not 0");
    rand_upper_a: assert property (
        mv.num == REG_REPLACE |=> rd_data[63:IDX_W] == '0)
        else $error("replace upper bits set");
    rand_write_a: assert property (
        tlb_write_rand |=> tlb_wr.wr) else $error("no random write");
    ctx_fault_a: assert property (
        fault_rd |=> rd_data[22:CTX_VPP_LSB] == $past(vpn, 3)
        && rd_data[3:0] == 4'h0) else $error("context pair wrong");
    load_miss_a: assert property (
        access_hit && !hit_valid && !access_store
        |=> load_miss_exc && !store_miss_exc) else $error("load miss");
    store_miss_a: assert property (
        access_hit && !hit_valid && access_store
        |=> store_miss_exc && !load_miss_exc) else $error("store miss");
    store_prot_a: assert property (
        access_hit && hit_valid && access_store
        |=> store_prot == !$past(hit_dirty)) else $error("store prot");
    address_space_id_skip_a: assert property (
        access_hit |=> address_space_id_ignore == $past(hit_global))
        else $error("address_space_id ignore wrong");
endmodule : tlb_mgmt_system_regs_checker

/* verif/tlb_mgmt_system_regs_tb_top.sv */
// Self-checking testbench for the TLB management registers
`timescale 1ns/1ns
module tlb_mgmt_system_regs_tb_top import tlb_regs_pkg::*;;
    // ========================================
    // Stimulus and observed signals
    logic clock = 0, rst_n = 0, retire = 0, probe_done = 0, probe_hit = 0;
    logic tlb_read = 0, tlb_write_idx = 0, tlb_write_rand = 0, tlb_exc = 0;
    logic hit_valid = 0, hit_dirty = 0, hit_global = 0, access_hit = 0;
    logic access_store = 0, address_space_id_ignore, load_miss_exc;
    logic store_miss_exc, store_prot;
    logic [IDX_W-1:0] probe_idx = '0, fixed_count = '0, rd_idx = '0;
    logic [63:0] fault_vaddr = '0, rd_data;
    reg_move_s mv = '0;
    tlb_lo_pair_s rd_pair;
    tlb_write_s tlb_wr;
    int n_mismatch = 0, num_checks = 0, cyc = 0;
    tlb_mgmt_system_regs i_dut (.clock, .rst_n, .mv, .retire, .probe_done,
        .probe_hit, .probe_idx, .tlb_read, .tlb_write_idx, .tlb_write_rand,
        .rd_pair, .fixed_count, .tlb_exc, .fault_vaddr, .hit_valid,
        .hit_dirty, .hit_global, .access_hit, .access_store, .rd_data,
        .tlb_wr, .address_space_id_ignore, .load_miss_exc, .store_miss_exc, .store_prot);
    tlb_entry_model i_tlb (.clock, .wr(tlb_wr), .rd_idx, .rd_pair);
    initial forever #4 clock = ~clock;
    // Hang guard, far above the under two hundred cycles needed
    always @(posedge clock) begin
        cyc++;
        if (cyc == 5000) begin
            n_mismatch++;
            finish_test();
        end
    end
    // ========================================
    // Shared tasks
    task automatic chk(string what, logic [63:0] exp, logic [63:0] got);
        num_checks++;
        if (got !== exp) begin
            n_mismatch++;
            $display("wrong value %s exp %h got %h", what, exp, got);
        end
    endtask : chk
    task automatic tick();
        @(negedge clock);
    endtask : tick
    // Strobes get an idle cycle after them so no edge sees two drives
    task automatic pulse(ref logic s);
        s = 1'h1;
        tick();
        s = 1'h0;
        tick();
    endtask : pulse
    task automatic wr_reg(logic [4:0] n, logic [63:0] d);
        mv = '{wr: 1'h1, num: n, data: d};
        tick();
        mv.wr = 1'h0;
        tick();
    endtask : wr_reg
    // Read data lands one cycle after the number is offered
    task automatic rd_reg(logic [4:0] n, string what, logic [63:0] exp);
        mv.num = n;
        tick();
        chk(what, exp, rd_data);
    endtask : rd_reg
    task automatic run(int k);
        retire = 1'h1;
        repeat (k) tick();
        retire = 1'h0;
        tick();
    endtask : run
    // ========================================
    // Scenarios
    task automatic t_reset();
        rd_reg(REG_REPLACE, "rand rst", 64'h3f);
        rd_reg(5'h1f, "unmapped", 64'h0);
    endtask : t_reset
    task automatic t_rand();
        fixed_count = 6'h04;
        wr_reg(REG_FIXED_COUNT, 64'h4);
        wr_reg(REG_REPLACE, 64'h0);
        run(3);
        rd_reg(REG_REPLACE, "rand dec", 64'h3c);
        tlb_write_rand = 1'h1;
        tick();
        tlb_write_rand = 1'h0;
        chk("rand idx", 64'h3c, 64'(tlb_wr.idx));
        tick();
        run(56);
        rd_reg(REG_REPLACE, "rand low", 64'h4);
        run(1);
        rd_reg(REG_REPLACE, "rand wrap", 64'h3f);
    endtask : t_rand
    task automatic t_lo();
        logic [63:0] e, o;
        o = 64'hffff_fabc_def0_1237;
        for (int g = 0; g < 2; g++) begin
            e = 64'hffff_f123_4567_89ae | 64'(g);
            wr_reg(REG_EVEN_LO, e);
            wr_reg(REG_ODD_LO, o);
            wr_reg(REG_PROBE_INDEX, 64'h8000_0005 + 64'(g));
            rd_reg(REG_EVEN_LO, "even", e & 64'h3ff_ffff_ffff);
            rd_reg(REG_PROBE_INDEX, "index", 64'h8000_0005 + 64'(g));
            tlb_write_idx = 1'h1;
            tick();
            tlb_write_idx = 1'h0;
            chk("wr idx", 64'h5 + 64'(g), 64'(tlb_wr.idx));
            chk("global", 64'(g), 64'(tlb_wr.pair.global_bit));
            chk("pfn0", 64'(e[41:6]), 64'(tlb_wr.pair.pfn0));
            tick();
        end
        wr_reg(REG_EVEN_LO, 64'h0);
        wr_reg(REG_ODD_LO, 64'h0);
        rd_idx = 6'h06;
        pulse(tlb_read);
        rd_reg(REG_EVEN_LO, "even rd", 64'h123_4567_89af);
        rd_reg(REG_ODD_LO, "odd rd", 64'h2bc_def0_1237);
    endtask : t_lo
    task automatic t_probe();
        probe_idx = 6'h09;
        pulse(probe_done);
        // A failed probe sets the flag and leaves the index alone
        rd_reg(REG_PROBE_INDEX, "probe miss", 64'h8000_0006);
        probe_hit = 1'h1;
        pulse(probe_done);
        rd_reg(REG_PROBE_INDEX, "probe hit", 64'h9);
    endtask : t_probe
    task automatic t_ctx();
        logic [63:0] c;
        c = 64'haaaa_bbbb_cccc_dddf;
        wr_reg(REG_CONTEXT, c);
        rd_reg(REG_CONTEXT, "ctx sw", c & ~64'hf);
        fault_vaddr = 64'h1234_5678_9abc_def0;
        pulse(tlb_exc);
        rd_reg(REG_CONTEXT, "ctx exc", {c[63:23], fault_vaddr[31:13],
            4'h0});
    endtask : t_ctx
    task automatic t_look();
        access_hit = 1'h1;
        for (int i = 0; i < 16; i++) begin
            {hit_valid, hit_dirty, hit_global, access_store} = 4'(i);
            tick();
            chk("lmiss", 64'(i < 8 && i % 2 == 0), 64'(load_miss_exc));
            chk("smiss", 64'(i < 8 && i % 2 == 1), 64'(store_miss_exc));
            chk("address_space_id", 64'(hit_global), 64'(address_space_id_ignore));
            chk("sprot", 64'(i >= 8 && (i & 4) == 0 && i % 2 == 1),
                64'(store_prot));
        end
        access_hit = 1'h0;
        tick();
    endtask : t_look
    task automatic finish_test();
        $display("checks %0d mismatches %0d", num_checks, n_mismatch);
        if (n_mismatch == 0 && num_checks > 0) begin
            $display("verification passed");
        end else begin
            $display("verification failed");
        end
        $finish;
    endtask : finish_test
    // ========================================
    // Main sequence
    initial begin
        repeat (8) tick();
        rst_n = 1'h1;
        t_reset();
        t_rand();
        t_lo();
        t_probe();
        t_ctx();
        t_look();
        finish_test();
    end
endmodule : tlb_mgmt_system_regs_tb_top
bind tlb_mgmt_system_regs tlb_mgmt_system_regs_checker i_chk (.clock,
    .rst_n, .mv, .probe_done, .probe_hit, .tlb_write_rand, .tlb_exc,
    .fault_vaddr, .hit_valid, .hit_dirty, .hit_global, .access_hit,
    .access_store, .rd_data, .tlb_wr, .address_space_id_ignore, .load_miss_exc,
    .store_miss_exc, .store_prot);
